/* File: mii_link_pkg.sv */
// Purpose: shared constants for the mii nibble data port ends
// Assumes: system clock 20 MHz on both ends
// Notes:   link clocks are generated by one divider of the system clock
package mii_link_pkg;
   localparam int          NIBBLE_W       = 4;
   localparam int          NIB_LSB        = 0;
   localparam int          NIB_MSB        = 3;
   localparam int          SYS_CLK_KHZ    = 20000;
   localparam int          SLOW_CLK_KHZ   = 2500;
   localparam int          FAST_CLK_KHZ   = 25000;
   // half period in system clocks; fast clock cannot exceed sys/2, clamp to one
   localparam int          SLOW_HALF_RAW  = SYS_CLK_KHZ / (2 * SLOW_CLK_KHZ);
   localparam int          FAST_HALF_RAW  = SYS_CLK_KHZ / (2 * FAST_CLK_KHZ);
   localparam int          SLOW_HALF      = (SLOW_HALF_RAW < 1) ? 1 : SLOW_HALF_RAW;
   localparam int          FAST_HALF      = (FAST_HALF_RAW < 1) ? 1 : FAST_HALF_RAW;
   localparam int          DIV_W          = 8;
   localparam logic [DIV_W-1:0] DIV_ZERO  = 8'h00;
   localparam logic [DIV_W-1:0] DIV_ONE   = 8'h01;
   localparam logic [NIBBLE_W-1:0] NIB_ZERO = 4'h0;
endpackage : mii_link_pkg

/* File: mii_link_if.sv */
// Purpose: pin bundle between the phy end and the mac end
// Assumes: both clocks of the link are driven by the phy end
// Notes:   no tristate here; receive outputs carry an enable instead
`timescale 1ns/10ps
interface mii_link_if;
   logic       rx_clk;
   logic [3:0] rx_data;
   logic       rx_valid;
   logic       rx_err;
   logic       rx_oe;
   logic       tx_clk;
   logic [3:0] tx_data;
   logic       tx_en;
   modport phy (output rx_clk, output rx_data, output rx_valid, output rx_err,
                output rx_oe, output tx_clk, input tx_data, input tx_en);
   modport mac (input rx_clk, input rx_data, input rx_valid, input rx_err,
                input rx_oe, input tx_clk, output tx_data, output tx_en);
endinterface : mii_link_if

/* File: mii_phy_end.sv */
// Purpose: phy end of the mii nibble data path
// Assumes: 20 MHz clk_i; medium side modelled as nibble streams
// Notes:   rx and tx clocks are divided from clk_i and driven out
`timescale 1ns/10ps
module mii_phy_end #(
   parameter int NW = mii_link_pkg::NIBBLE_W
) (
   // system
   input  wire logic          clk_i,
   input  wire logic          srst_i,
   input  wire logic          ce_i,
   // mode and control
   input  wire logic          speed_100_i,
   input  wire logic          receive_output_tristate_control_i,
   // medium receive side
   input  wire logic          med_rx_valid_i,
   input  wire logic [NW-1:0] med_rx_data_i,
   input  wire logic          med_rx_err_i,
   input  wire logic          med_false_carrier_i,
   // medium transmit side
   output logic               med_tx_valid_o,
   output logic [NW-1:0]      med_tx_data_o,
   output logic               med_tx_active_o,
   // link
   mii_link_if.phy            link
);
   ////////////////////////////////////////////////////////////////////////
   logic [mii_link_pkg::DIV_W-1:0] div_reg, div_next;
   logic                           lclk_reg, lclk_next;
   logic [mii_link_pkg::DIV_W-1:0] half;
   logic                           rise;

   // one divider serves both link clocks, they share frequency per speed
   always_comb begin
      half = speed_100_i ? mii_link_pkg::DIV_W'(mii_link_pkg::FAST_HALF)
                         : mii_link_pkg::DIV_W'(mii_link_pkg::SLOW_HALF);
      div_next  = div_reg;
      lclk_next = lclk_reg;
      rise      = 1'b0;
      if (ce_i) begin
         if (div_reg + mii_link_pkg::DIV_ONE >= half) begin
            div_next  = mii_link_pkg::DIV_ZERO;
            lclk_next = ~lclk_reg;
            rise      = ~lclk_reg;
         end else begin
            div_next = div_reg + mii_link_pkg::DIV_ONE;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         div_reg  <= mii_link_pkg::DIV_ZERO;
         lclk_reg <= 1'b0;
      end else begin
         div_reg  <= div_next;
         lclk_reg <= lclk_next;
      end
   end

   assign link.tx_clk = lclk_reg;
   assign link.rx_clk = lclk_reg;

   ////////////////////////////////////////////////////////////////////////
   // receive: outputs change with the rising edge of the link clock
   logic [NW-1:0] rxd_reg, rxd_next;
   logic          rxdv_reg, rxdv_next;
   logic          rxer_reg, rxer_next;

   always_comb begin
      rxd_next  = rxd_reg;
      rxdv_next = rxdv_reg;
      rxer_next = rxer_reg;
      if (rise) begin
         rxdv_next = med_rx_valid_i;
         rxd_next  = med_rx_valid_i ? med_rx_data_i : mii_link_pkg::NIB_ZERO;
         // 10 Mb/s leaves the error line low
         rxer_next = speed_100_i &&
                     ((med_rx_valid_i && med_rx_err_i) ||
                      (!med_rx_valid_i && med_false_carrier_i));
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rxd_reg  <= mii_link_pkg::NIB_ZERO;
         rxdv_reg <= 1'b0;
         rxer_reg <= 1'b0;
      end else begin
         rxd_reg  <= rxd_next;
         rxdv_reg <= rxdv_next;
         rxer_reg <= rxer_next;
      end
   end

   assign link.rx_data  = rxd_reg;
   assign link.rx_valid = rxdv_reg;
   // tristate control releases the receive outputs, error included
   assign link.rx_err   = rxer_reg & ~receive_output_tristate_control_i;
   assign link.rx_oe    = ~receive_output_tristate_control_i;

   ////////////////////////////////////////////////////////////////////////
   // transmit: mac pins are from another domain, synchronise first
   logic [NW-1:0] txd_s1_reg, txd_s2_reg;
   logic          txen_s1_reg, txen_s2_reg;
   logic [NW-1:0] mtxd_reg, mtxd_next;
   logic          mtxv_reg, mtxv_next;
   logic          mact_reg, mact_next;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         txd_s1_reg  <= mii_link_pkg::NIB_ZERO;
         txd_s2_reg  <= mii_link_pkg::NIB_ZERO;
         txen_s1_reg <= 1'b0;
         txen_s2_reg <= 1'b0;
      end else if (ce_i) begin
         txd_s1_reg  <= link.tx_data;
         txd_s2_reg  <= txd_s1_reg;
         txen_s1_reg <= link.tx_en;
         txen_s2_reg <= txen_s1_reg;
      end
   end

   // the synchroniser lags two clocks; the mac changes three clocks after our rising edge,
   // so the sampled pair is stable by the next rise at 10 Mb/s, by the third rise at 100 Mb/s
   always_comb begin
      mtxd_next = mtxd_reg;
      mtxv_next = 1'b0;
      mact_next = mact_reg;
      if (rise) begin
         mact_next = txen_s2_reg;
         if (txen_s2_reg) begin
            mtxd_next = txd_s2_reg;
            mtxv_next = 1'b1;
         end else begin
            mtxd_next = mii_link_pkg::NIB_ZERO;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mtxd_reg <= mii_link_pkg::NIB_ZERO;
         mtxv_reg <= 1'b0;
         mact_reg <= 1'b0;
      end else if (ce_i) begin
         mtxd_reg <= mtxd_next;
         mtxv_reg <= mtxv_next;
         mact_reg <= mact_next;
      end
   end

   assign med_tx_data_o   = mtxd_reg;
   assign med_tx_valid_o  = mtxv_reg;
   assign med_tx_active_o = mact_reg;
endmodule : mii_phy_end

/* File: mii_mac_end.sv */
// Purpose: mac end of the mii nibble data path
// Assumes: link clocks arrive from the phy end, sampled by clk_i
// Notes:   user words are nibbles; transmit is paced by tx clock rises
`timescale 1ns/10ps
module mii_mac_end #(
   parameter int NW = mii_link_pkg::NIBBLE_W
) (
   // system
   input  wire logic          clk_i,
   input  wire logic          srst_i,
   input  wire logic          ce_i,
   // user transmit
   input  wire logic          tx_valid_i,
   input  wire logic [NW-1:0] tx_data_i,
   input  wire logic          tx_last_i,
   output logic               tx_ready_o,
   // user receive
   output logic               rx_valid_o,
   output logic [NW-1:0]      rx_data_o,
   output logic               rx_err_o,
   // link
   mii_link_if.mac            link
);
   ////////////////////////////////////////////////////////////////////////
   logic [3:0]    s1_reg, s2_reg, p_reg;
   logic [NW-1:0] rd1_reg, rd2_reg;
   logic          rxr, txr;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s1_reg  <= 4'h0;
         s2_reg  <= 4'h0;
         p_reg   <= 4'h0;
         rd1_reg <= mii_link_pkg::NIB_ZERO;
         rd2_reg <= mii_link_pkg::NIB_ZERO;
      end else if (ce_i) begin
         s1_reg  <= {link.rx_clk, link.tx_clk, link.rx_valid, link.rx_err};
         s2_reg  <= s1_reg;
         p_reg   <= s2_reg;
         rd1_reg <= link.rx_data;
         rd2_reg <= rd1_reg;
      end
   end

   assign rxr = s2_reg[3] & ~p_reg[3];
   assign txr = s2_reg[2] & ~p_reg[2];

   ////////////////////////////////////////////////////////////////////////
   logic [NW-1:0] rxo_reg, rxo_next;
   logic          rxv_reg, rxv_next, rxe_reg, rxe_next;

   always_comb begin
      rxo_next = rxo_reg;
      rxv_next = 1'b0;
      rxe_next = 1'b0;
      if (ce_i && rxr) begin
         rxv_next = s2_reg[1];
         rxo_next = rd2_reg;
         rxe_next = s2_reg[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rxo_reg <= mii_link_pkg::NIB_ZERO;
         rxv_reg <= 1'b0;
         rxe_reg <= 1'b0;
      end else if (ce_i) begin
         rxo_reg <= rxo_next;
         rxv_reg <= rxv_next;
         rxe_reg <= rxe_next;
      end
   end

   assign rx_data_o  = rxo_reg;
   assign rx_valid_o = rxv_reg;
   assign rx_err_o   = rxe_reg;

   ////////////////////////////////////////////////////////////////////////
   // one nibble per tx clock rise; enable drops on the rise after the last
   logic [NW-1:0] txd_reg, txd_next;
   logic          txen_reg, txen_next;

   assign tx_ready_o = ce_i & txr;

   always_comb begin
      txd_next  = txd_reg;
      txen_next = txen_reg;
      if (ce_i && txr) begin
         if (tx_valid_i) begin
            txd_next  = tx_data_i;
            txen_next = 1'b1;
         end else begin
            txen_next = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         txd_reg  <= mii_link_pkg::NIB_ZERO;
         txen_reg <= 1'b0;
      end else begin
         txd_reg  <= txd_next;
         txen_reg <= txen_next;
      end
   end

   assign link.tx_data = txd_reg;
   assign link.tx_en   = txen_reg;
endmodule : mii_mac_end

/* File: mii_nibble_data_port_assertions.sv */
// Purpose: link checks for the mii nibble data port
// Assumes: speed and tristate control change only while in reset
// Notes:   sees the phy outputs on the shared link and the phy mode inputs only
`timescale 1ns/10ps
module mii_nibble_data_port_assertions (
   // system
   input wire logic       clk_i,
   input wire logic       srst_i,
   // mode
   input wire logic       speed_100_i,
   input wire logic       receive_output_tristate_control_i,
   // link
   input wire logic       rx_clk,
   input wire logic [3:0] rx_data,
   input wire logic       rx_valid,
   input wire logic       rx_err,
   input wire logic       rx_oe,
   input wire logic       tx_clk
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   ////////////////////////////////////////////////////////////
   rx_err_sync_a: assert property ($changed(rx_err) |-> $rose(rx_clk))
      else $error("rx error moved off a link clock rise");
   rx_err_slow_a: assert property (!speed_100_i |-> !rx_err)
      else $error("rx error raised at low speed");
   rx_release_a: assert property
      (receive_output_tristate_control_i |-> !rx_oe && !rx_err)
      else $error("rx outputs not released");
   rx_data_sync_a: assert property ($changed(rx_data) |-> $rose(rx_clk))
      else $error("rx data moved off a link clock rise");
   rx_valid_sync_a: assert property ($changed(rx_valid) |-> $rose(rx_clk))
      else $error("rx valid moved off a link clock rise");
   clk_slow_a: assert property (!speed_100_i && $rose(tx_clk) |->
      tx_clk[*4] ##1 !tx_clk[*4] ##1 tx_clk)
      else $error("slow tx clock period wrong");
   clk_fast_a: assert property (speed_100_i && $rose(tx_clk) |->
      ##1 !tx_clk ##1 tx_clk)
      else $error("fast tx clock period wrong");
   clk_shared_a: assert property (rx_clk == tx_clk)
      else $error("rx and tx clocks differ");
endmodule : mii_nibble_data_port_assertions

/* File: mii_nibble_data_port_bench.sv */
// Purpose: bench for the mii nibble data port, both ends joined
// Assumes: phy clock enable held high; mode set only in reset
// Notes:   rx result checked a fixed 3 clocks after the sampling rise
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module mii_nibble_data_port_bench;
   logic       clk_i = 0;
   logic       srst_i = 1;
   logic       spd = 0;
   logic       tri_c = 0;
   logic       mv = 0;
   logic       me = 0;
   logic       mf = 0;
   logic [3:0] md = 4'h0;
   logic       tv = 0;
   logic [3:0] td = 4'h0;
   logic       mtv, mta, tr, rv, re;
   logic [3:0] mtd, rd;
   int         fails = 0;
   int         cmp_count = 0;
   mii_link_if link();
   always #25 clk_i = ~clk_i;
   mii_phy_end i_mii_phy_end (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
      .speed_100_i(spd), .receive_output_tristate_control_i(tri_c),
      .med_rx_valid_i(mv), .med_rx_data_i(md), .med_rx_err_i(me),
      .med_false_carrier_i(mf), .med_tx_valid_o(mtv), .med_tx_data_o(mtd),
      .med_tx_active_o(mta), .link(link));
   mii_mac_end i_mii_mac_end (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
      .tx_valid_i(tv), .tx_data_i(td), .tx_last_i(1'b0), .tx_ready_o(tr),
      .rx_valid_o(rv), .rx_data_o(rd), .rx_err_o(re), .link(link));
   mii_nibble_data_port_assertions i_mii_nibble_data_port_assertions (
      .clk_i(clk_i), .srst_i(srst_i), .speed_100_i(spd),
      .receive_output_tristate_control_i(tri_c), .rx_clk(link.rx_clk),
      .rx_data(link.rx_data), .rx_valid(link.rx_valid), .rx_err(link.rx_err),
      .rx_oe(link.rx_oe), .tx_clk(link.tx_clk));
   ////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : finish_test
   task automatic do_reset(input logic s, input logic t);
      @(posedge clk_i) begin
         srst_i <= 1;
         spd <= s;
         tri_c <= t;
      end
      repeat (16) @(posedge clk_i);
      srst_i <= 0;
   endtask : do_reset
   // returns just after the edge on which the link clock went high
   task automatic wait_rise();
      logic last;
      #1;
      last = link.rx_clk;
      forever begin
         @(posedge clk_i);
         #1;
         if (link.rx_clk && !last) break;
         last = link.rx_clk;
      end
   endtask : wait_rise
   task automatic rx_nib(input logic [3:0] d, input logic v, e, f, xe);
      wait_rise();
      @(posedge clk_i) begin
         md <= d;
         mv <= v;
         me <= e;
         mf <= f;
      end
      wait_rise();
      if (v && !tri_c) `CHK(link.rx_data, d)
      `CHK(link.rx_oe, !tri_c)
      // two synchroniser stages plus the output register: the pulse stands
      // in the third clock after the rise and is gone in the fourth
      repeat (3) @(posedge clk_i);
      #1;
      `CHK(re, xe)
      if (v && !tri_c) `CHK(rd, d)
      if (v && !tri_c) `CHK(rv, 1'b1)
      if (!v) `CHK(rv, 1'b0)
   endtask : rx_nib
   task automatic tx_nib(input logic [3:0] d);
      int n;
      @(posedge clk_i) begin
         tv <= 1;
         td <= d;
      end
      // ready is sampled mid-cycle so one offer is taken exactly once
      do @(negedge clk_i); while (tr !== 1'b1);
      @(posedge clk_i) tv <= 0;
      #1;
      `CHK(link.tx_en, 1'b1)
      `CHK(link.tx_data, d)
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (mtv !== 1'b1 && n < 40);
      `CHK(mtv, 1'b1)
      `CHK(mtd, d)
      `CHK(mta, 1'b1)
   endtask : tx_nib
   task automatic tx_idle();
      int n;
      n = 0;
      @(posedge clk_i) td <= 4'hf;
      repeat (30) begin
         @(posedge clk_i);
         #1;
         if (mtv === 1'b1) n++;
      end
      `CHK(n, 0)
      `CHK(mtd, 4'h0)
      `CHK(link.tx_en, 1'b0)
      `CHK(mta, 1'b0)
   endtask : tx_idle
   ////////////////////////////////////////////////////////////
   initial begin
      for (int s = 0; s < 2; s++) begin
         do_reset(s[0], 1'b0);
         for (int i = 0; i < 4; i++)
            rx_nib(4'h1 << i, 1'b1, i[0], i[1], s[0] & i[0]);
         rx_nib(4'h0, 1'b0, 1'b0, 1'b1, s[0]);
         for (int i = 0; i < 4; i++)
            tx_nib(4'h1 << i);
         tx_nib(4'ha);
         tx_idle();
      end
      do_reset(1'b1, 1'b1);
      rx_nib(4'h5, 1'b1, 1'b1, 1'b0, 1'b0);
      rx_nib(4'h0, 1'b0, 1'b0, 1'b1, 1'b0);
      finish_test();
   end
   initial begin
      #(6000 * 50);
      fails++;
      finish_test();
   end
endmodule : mii_nibble_data_port_bench
